// file: pcx_crossbar.sv
// Purpose: priority crossbar and port output logic for four 8-bit ports, AXI4-Lite registers
// Assumes: one clock; pins and peripheral lines synchronous to aclk
// Notes: pad outputs and peripheral inputs lag the configuration by one cycle
// Contract
// R1: a peripheral reaches pins only when its crossbar enable bits are one
// R2: first serial port enabled puts transmit on port 0 bit 0, receive bit 1
// R3: a peripheral with clear enable bits has no pin connection at all
// R4: serial peripherals get all their signals together, never transmit alone
// R5: unallocated pins act as general-purpose io through port data registers
// R6: allocated pins follow their peripheral; port data writes do not move them
// R7: plain port data reads return the sampled pin level
// R8: read-modify-write read phase returns the data latch instead of the pin
// R9: all output drivers stay off until the global crossbar enable is one
// R10: software configures the crossbar fully before setting the global enable
// R11: pins given to peripheral inputs keep their output driver off
// R12: push-pull drives low for zero and high for one
// R13: open-drain drives low for zero and floats for one
// R14: mode bit one selects push-pull, zero open-drain; reset is open-drain
// R15: mode bits govern both allocated and general-purpose pins
// R16: serial bus lines and mode-0 serial receive lines are forced open-drain
// R17: decode order holds with low-port reservation off and port 1 digital
// R18: enabled signals take the lowest free pins in fixed priority order
// R19: analog-input pins are skipped and read back as zero
// R20: low-port reservation leaves port 0 bits 7, 6 and, multiplexed, 5 free
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`include "pcx_regs.svh"
`default_nettype none
module pcx_crossbar #(
  parameter int NPORT = 4,
  parameter int NSIG = 33,
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT*8-1:0] pin_i,
  output logic [NPORT*8-1:0] pin_o,
  output logic [NPORT*8-1:0] pin_oe,
  input wire logic [NSIG-1:0] periph_out,
  input wire logic [NSIG-1:0] periph_drv,
  output logic [NSIG-1:0] periph_in,
  input wire logic uart0_mode0,
  input wire logic uart1_mode0,
  input wire logic spi_three_wire,
  input wire logic emif_multiplexed
);
  localparam int NPIN = NPORT * 8;

  pcx_pkg::pcx_byte_t crossbar_cfg_a_ff;
  pcx_pkg::pcx_byte_t crossbar_cfg_b_ff;
  pcx_pkg::pcx_byte_t crossbar_cfg_c_ff;
  pcx_pkg::pcx_byte_t crossbar_cfg_d_ff;
  logic [NPORT-1:0][7:0] latch_ff;
  logic [NPORT-1:0][7:0] port_output_mode_bits_ff;
  pcx_pkg::pcx_byte_t port1_input_mode_bits_ff;

  pcx_pkg::pcx_wr_e wr_st_ff;
  pcx_pkg::pcx_wr_e nxt_wr_st;
  logic [AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp;
  logic wr_go;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_lane0;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [AW-1:0] rd_addr_ff;
  pcx_pkg::pcx_byte_t rd_val;

  logic crossbar_global_enable;
  logic extmem_low_port_reserve;
  logic [NSIG-1:0] sig_en;
  logic [NSIG-1:0] in_only;
  logic [NSIG-1:0] od_force;
  logic [NPIN-1:0] analog_mask;
  logic [NPIN-1:0] reserve_mask;
  logic [NPIN-1:0] pin_free;
  logic [NPIN-1:0] pin_level;
  logic [NPIN-1:0] pin_alloc;
  logic [NPIN-1:0][5:0] pin_sig;
  logic [NSIG-1:0] sig_alloc;
  logic [NSIG-1:0][4:0] sig_pin;

  // address decode shared by both channels
  function automatic logic reg_hit(input logic [AW-1:0] a, input logic is_wr);
    logic hit;
    hit = 1'b0;
    if (a[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (a <= `PCX_OFF_CFG_D) begin
      hit = 1'b1;
    end else if ({a[7:4], 4'h0} == `PCX_OFF_DATA_BASE && 32'(a[3:2]) < NPORT) begin
      hit = 1'b1;
    end else if ({a[7:4], 4'h0} == `PCX_OFF_MODE_BASE && 32'(a[3:2]) < NPORT) begin
      hit = 1'b1;
    end else if (a == `PCX_OFF_P1_MDIN) begin
      hit = 1'b1;
    end else if ({a[7:4], 4'h0} == `PCX_OFF_LATCH_BASE && 32'(a[3:2]) < NPORT) begin
      hit = !is_wr;
    end
    return hit;
  endfunction

  // write channel: address and data taken in either order
  assign s_axi_awready = wr_st_ff == pcx_pkg::PCX_WR_IDLE || wr_st_ff == pcx_pkg::PCX_WR_HAVE_D;
  assign s_axi_wready = wr_st_ff == pcx_pkg::PCX_WR_IDLE || wr_st_ff == pcx_pkg::PCX_WR_HAVE_A;
  assign s_axi_bvalid = wr_st_ff == pcx_pkg::PCX_WR_RESP;
  assign s_axi_bresp = bresp_ff;
  assign wr_addr = (wr_st_ff == pcx_pkg::PCX_WR_HAVE_A) ? awaddr_ff : s_axi_awaddr;
  assign wr_data = (wr_st_ff == pcx_pkg::PCX_WR_HAVE_D) ? wdata_ff : s_axi_wdata;
  assign wr_lane0 = (wr_st_ff == pcx_pkg::PCX_WR_HAVE_D) ? wstrb_ff[0] : s_axi_wstrb[0];
  assign nxt_bresp = reg_hit(wr_addr, 1'b1) ? 2'h0 : 2'h2;

  always_comb begin
    nxt_wr_st = wr_st_ff;
    wr_go = 1'b0;
    case (wr_st_ff)
      pcx_pkg::PCX_WR_IDLE: begin
        if (s_axi_awvalid && s_axi_wvalid) begin
          nxt_wr_st = pcx_pkg::PCX_WR_RESP;
          wr_go = 1'b1;
        end else if (s_axi_awvalid) begin
          nxt_wr_st = pcx_pkg::PCX_WR_HAVE_A;
        end else if (s_axi_wvalid) begin
          nxt_wr_st = pcx_pkg::PCX_WR_HAVE_D;
        end
      end
      pcx_pkg::PCX_WR_HAVE_A: begin
        if (s_axi_wvalid) begin
          nxt_wr_st = pcx_pkg::PCX_WR_RESP;
          wr_go = 1'b1;
        end
      end
      pcx_pkg::PCX_WR_HAVE_D: begin
        if (s_axi_awvalid) begin
          nxt_wr_st = pcx_pkg::PCX_WR_RESP;
          wr_go = 1'b1;
        end
      end
      pcx_pkg::PCX_WR_RESP: begin
        if (s_axi_bready) begin
          nxt_wr_st = pcx_pkg::PCX_WR_IDLE;
        end
      end
      default: begin
        nxt_wr_st = pcx_pkg::PCX_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_ff <= pcx_pkg::PCX_WR_IDLE;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bresp_ff <= 2'h0;
    end else begin
      wr_st_ff <= nxt_wr_st;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        bresp_ff <= nxt_bresp;
      end
    end
  end

  // crossbar configuration; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crossbar_cfg_a_ff <= `PCX_RST_CFG;
      crossbar_cfg_b_ff <= `PCX_RST_CFG;
      crossbar_cfg_c_ff <= `PCX_RST_CFG;
      crossbar_cfg_d_ff <= `PCX_RST_CFG;
    end else if (wr_go && wr_lane0) begin
      if (wr_addr == `PCX_OFF_CFG_A) begin
        crossbar_cfg_a_ff <= wr_data[7:0];
      end else if (wr_addr == `PCX_OFF_CFG_B) begin
        crossbar_cfg_b_ff <= wr_data[7:0];
      end else if (wr_addr == `PCX_OFF_CFG_C) begin
        crossbar_cfg_c_ff <= wr_data[7:0];
      end else if (wr_addr == `PCX_OFF_CFG_D) begin
        crossbar_cfg_d_ff <= wr_data[7:0];
      end
    end
  end

  // latch always stores; it only reaches pins it owns
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_ff <= {NPORT{`PCX_RST_LATCH}};
    end else if (wr_go && wr_lane0 && {wr_addr[7:4], 4'h0} == `PCX_OFF_DATA_BASE && reg_hit(wr_addr, 1'b1)) begin
      latch_ff[wr_addr[3:2]] <= wr_data[7:0]; // [R5] [R6]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_output_mode_bits_ff <= {NPORT{`PCX_RST_MODE}}; // [R14]
    end else if (wr_go && wr_lane0 && {wr_addr[7:4], 4'h0} == `PCX_OFF_MODE_BASE && reg_hit(wr_addr, 1'b1)) begin
      port_output_mode_bits_ff[wr_addr[3:2]] <= wr_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port1_input_mode_bits_ff <= `PCX_RST_MDIN;
    end else if (wr_go && wr_lane0 && wr_addr == `PCX_OFF_P1_MDIN) begin
      port1_input_mode_bits_ff <= wr_data[7:0];
    end
  end

  // read channel: one cycle from address to data
  always_comb begin
    rd_val = 8'h00;
    if (s_axi_araddr == `PCX_OFF_CFG_A) begin
      rd_val = crossbar_cfg_a_ff;
    end else if (s_axi_araddr == `PCX_OFF_CFG_B) begin
      rd_val = crossbar_cfg_b_ff;
    end else if (s_axi_araddr == `PCX_OFF_CFG_C) begin
      rd_val = crossbar_cfg_c_ff;
    end else if (s_axi_araddr == `PCX_OFF_CFG_D) begin
      rd_val = crossbar_cfg_d_ff;
    end else if ({s_axi_araddr[7:4], 4'h0} == `PCX_OFF_DATA_BASE) begin
      rd_val = pin_level[s_axi_araddr[3:2]*8 +: 8]; // [R7]
    end else if ({s_axi_araddr[7:4], 4'h0} == `PCX_OFF_MODE_BASE) begin
      rd_val = port_output_mode_bits_ff[s_axi_araddr[3:2]];
    end else if (s_axi_araddr == `PCX_OFF_P1_MDIN) begin
      rd_val = port1_input_mode_bits_ff;
    end else if ({s_axi_araddr[7:4], 4'h0} == `PCX_OFF_LATCH_BASE) begin
      rd_val = latch_ff[s_axi_araddr[3:2]]; // [R8]
    end
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
      rd_addr_ff <= '0;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rd_addr_ff <= s_axi_araddr;
      rdata_ff <= reg_hit(s_axi_araddr, 1'b0) ? {24'h00_0000, rd_val} : 32'h0000_0000;
      rresp_ff <= reg_hit(s_axi_araddr, 1'b0) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // peripheral enables in priority order
  assign crossbar_global_enable = crossbar_cfg_c_ff[`PCX_C_CROSSBAR_GLOBAL_ENABLE];
  assign extmem_low_port_reserve = crossbar_cfg_c_ff[`PCX_C_EXTMEM_LOW_PORT_RESERVE];

  always_comb begin
    sig_en = '0;
    sig_en[`PCX_SIG_TX0] = crossbar_cfg_a_ff[`PCX_A_UART0]; // [R1] [R4]
    sig_en[`PCX_SIG_RX0] = crossbar_cfg_a_ff[`PCX_A_UART0]; // [R4]
    sig_en[4:2] = {3{crossbar_cfg_a_ff[`PCX_A_SPI]}};
    sig_en[`PCX_SIG_NSS] = crossbar_cfg_a_ff[`PCX_A_SPI] && !spi_three_wire;
    sig_en[`PCX_SIG_SDA] = crossbar_cfg_a_ff[`PCX_A_SMB];
    sig_en[`PCX_SIG_SCL] = crossbar_cfg_a_ff[`PCX_A_SMB];
    sig_en[`PCX_SIG_TX1] = crossbar_cfg_c_ff[`PCX_C_UART1];
    sig_en[`PCX_SIG_RX1] = crossbar_cfg_c_ff[`PCX_C_UART1];
    for (int k = 0; k < 6; k++) begin
      sig_en[`PCX_SIG_CEX0 + k] = 3'(k) < crossbar_cfg_a_ff[`PCX_A_PCA_HI:`PCX_A_PCA_LO];
    end
    sig_en[16] = crossbar_cfg_a_ff[`PCX_A_ECI];
    sig_en[17] = crossbar_cfg_a_ff[`PCX_A_CP0];
    sig_en[18] = crossbar_cfg_b_ff[`PCX_B_CP1];
    sig_en[19] = crossbar_cfg_d_ff[`PCX_D_CP2];
    sig_en[20] = crossbar_cfg_b_ff[`PCX_B_T0];
    sig_en[21] = crossbar_cfg_b_ff[`PCX_B_INT0];
    sig_en[22] = crossbar_cfg_b_ff[`PCX_B_T1];
    sig_en[23] = crossbar_cfg_b_ff[`PCX_B_INT1];
    sig_en[24] = crossbar_cfg_b_ff[`PCX_B_T2];
    sig_en[25] = crossbar_cfg_b_ff[`PCX_B_TIMER2_EXTERNAL_TRIGGER];
    sig_en[26] = crossbar_cfg_d_ff[`PCX_D_T3];
    sig_en[27] = crossbar_cfg_d_ff[`PCX_D_T3EX];
    sig_en[28] = crossbar_cfg_c_ff[`PCX_C_T4];
    sig_en[29] = crossbar_cfg_d_ff[`PCX_D_T4EX];
    sig_en[30] = crossbar_cfg_b_ff[`PCX_B_SYSCLK];
    sig_en[31] = crossbar_cfg_c_ff[`PCX_C_CNV0];
    sig_en[32] = crossbar_cfg_c_ff[`PCX_C_CNV2];
  end

  // receive lines turn two-way in serial mode 0
  always_comb begin
    in_only = `PCX_INPUT_ONLY;
    in_only[`PCX_SIG_RX0] = !uart0_mode0;
    in_only[`PCX_SIG_RX1] = !uart1_mode0;
    od_force = '0;
    od_force[`PCX_SIG_SDA] = 1'b1; // [R16]
    od_force[`PCX_SIG_SCL] = 1'b1; // [R16]
    od_force[`PCX_SIG_RX0] = uart0_mode0; // [R16]
    od_force[`PCX_SIG_RX1] = uart1_mode0; // [R16]
  end

  // only port 1 has input mode bits; zero means analog
  assign analog_mask = {{(NPIN-16){1'b0}}, ~port1_input_mode_bits_ff, 8'h00};
  assign reserve_mask = {{(NPIN-8){1'b0}}, extmem_low_port_reserve, extmem_low_port_reserve,
                         extmem_low_port_reserve && emif_multiplexed, 5'h00}; // [R20]
  assign pin_free = ~analog_mask & ~reserve_mask; // [R17] [R19]
  assign pin_level = pin_i & ~analog_mask; // [R19]

  pcx_alloc #(
    .NSIG(NSIG),
    .NPIN(NPIN)
  ) u_alloc (
    .sig_en(sig_en),
    .pin_free(pin_free),
    .pin_alloc(pin_alloc),
    .pin_sig(pin_sig),
    .sig_alloc(sig_alloc),
    .sig_pin(sig_pin)
  );

  // unallocated peripherals see zero, not a stray pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_in <= '0;
    end else begin
      for (int s = 0; s < NSIG; s++) begin
        periph_in[s] <= sig_alloc[s] && pin_level[sig_pin[s]]; // [R3]
      end
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_pin
      pcx_pkg::pcx_drive_s drive;
      logic [5:0] sel;
      assign sel = pin_sig[gp];
      always_comb begin
        if (pin_alloc[gp]) begin
          drive.val = periph_out[sel]; // [R6]
          drive.drv = periph_drv[sel] && !in_only[sel]; // [R11]
          drive.od = !port_output_mode_bits_ff[gp/8][gp%8] || od_force[sel]; // [R15] [R16]
        end else begin
          drive.val = latch_ff[gp/8][gp%8]; // [R5]
          drive.drv = 1'b1;
          drive.od = !port_output_mode_bits_ff[gp/8][gp%8]; // [R14] [R15]
        end
      end
      pcx_pad u_pad (
        .aclk(aclk),
        .aresetn(aresetn),
        .drive(drive),
        .enable(crossbar_global_enable), // [R9]
        .pin_o(pin_o[gp]),
        .pin_oe(pin_oe[gp])
      );
    end
  endgenerate

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_drivers_off: assert property (!crossbar_global_enable |=> pin_oe == '0) // [R9]
    else $error("driver on while crossbar disabled");
  a_uart0_place: assert property (crossbar_cfg_a_ff[`PCX_A_UART0] |-> // [R2]
    sig_pin[`PCX_SIG_TX0] == 5'h00 && sig_pin[`PCX_SIG_RX0] == 5'h01 && sig_alloc[1:0] == 2'h3)
    else $error("first serial port not on port 0 bits 0 and 1");
  a_no_stray_input: assert property (1'b1 |=> (periph_in & ~$past(sig_en)) == '0) // [R3]
    else $error("disabled peripheral sees a pin");
  a_serial_pairs: assert property (sig_alloc[0] == sig_alloc[1] && sig_alloc[8] == sig_alloc[9] // [R4]
    && sig_alloc[6] == sig_alloc[7])
    else $error("serial signals split");
  a_only_enabled: assert property ((sig_alloc & ~sig_en) == '0) // [R1]
    else $error("pin given to disabled signal");
  a_input_undriven: assert property (pin_alloc[1] && in_only[pin_sig[1]] |=> !pin_oe[1]) // [R11]
    else $error("input pin driven");
  a_forced_od: assert property (pin_alloc[1] && od_force[pin_sig[1]] |=> !(pin_oe[1] && pin_o[1])) // [R16]
    else $error("forced open-drain pin driven high");
  a_gpio_push: assert property (crossbar_global_enable && !pin_alloc[31] && port_output_mode_bits_ff[3][7] // [R12]
    |=> pin_oe[31] && pin_o[31] == $past(latch_ff[3][7]))
    else $error("push-pull gpio not following latch");
  a_od_float: assert property (!pin_alloc[30] && !port_output_mode_bits_ff[3][6] && latch_ff[3][6] // [R13]
    |=> !pin_oe[30])
    else $error("open-drain one is driven");
  a_mode_reset: assert property (disable iff (1'b0) !aresetn |=> port_output_mode_bits_ff == '0) // [R14]
    else $error("mode bits not open-drain after reset");
  a_analog_zero: assert property ($rose(s_axi_rvalid) && rd_addr_ff == `PCX_OFF_DATA_BASE + 8'h04 // [R19]
    |-> (s_axi_rdata[7:0] & ~$past(port1_input_mode_bits_ff)) == 8'h00)
    else $error("analog pin reads nonzero");
  a_rmw_latch: assert property ($rose(s_axi_rvalid) && {rd_addr_ff[7:4], 4'h0} == `PCX_OFF_LATCH_BASE // [R8]
    |-> s_axi_rdata[7:0] == 8'($past(latch_ff) >> {rd_addr_ff[3:2], 3'h0}))
    else $error("latch read mismatch");
  a_reserve_skip: assert property (extmem_low_port_reserve |-> pin_alloc[7:6] == 2'h0) // [R20]
    else $error("reserved pin allocated");

  c_uart0_on: cover property (crossbar_global_enable && sig_alloc[`PCX_SIG_TX0]);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_reserve_mux: cover property (extmem_low_port_reserve && emif_multiplexed && sig_alloc[0]);
  c_analog_skip: cover property (!port1_input_mode_bits_ff[0] && |sig_en[32:10]);
endmodule // pcx_crossbar
`default_nettype wire

// file: pcx_regs.svh
// Purpose: register offsets, field positions and reset values of the crossbar and port block
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register
// Notes: definitions only
`ifndef PCX_REGS_SVH
`define PCX_REGS_SVH

`define PCX_OFF_CFG_A 8'h00
`define PCX_OFF_CFG_B 8'h04
`define PCX_OFF_CFG_C 8'h08
`define PCX_OFF_CFG_D 8'h0c
`define PCX_OFF_DATA_BASE 8'h10
`define PCX_OFF_MODE_BASE 8'h20
`define PCX_OFF_P1_MDIN 8'h30
`define PCX_OFF_LATCH_BASE 8'h40

// crossbar_cfg_a fields
`define PCX_A_SMB 0
`define PCX_A_SPI 1
`define PCX_A_UART0 2
`define PCX_A_PCA_LO 3
`define PCX_A_PCA_HI 5
`define PCX_A_ECI 6
`define PCX_A_CP0 7
// crossbar_cfg_b fields
`define PCX_B_CP1 0
`define PCX_B_T0 1
`define PCX_B_INT0 2
`define PCX_B_T1 3
`define PCX_B_INT1 4
`define PCX_B_T2 5
`define PCX_B_TIMER2_EXTERNAL_TRIGGER 6
`define PCX_B_SYSCLK 7
// crossbar_cfg_c fields
`define PCX_C_CNV0 0
`define PCX_C_CNV2 1
`define PCX_C_UART1 2
`define PCX_C_T4 3
`define PCX_C_CROSSBAR_GLOBAL_ENABLE 4
`define PCX_C_EXTMEM_LOW_PORT_RESERVE 5
// crossbar_cfg_d fields
`define PCX_D_T3 0
`define PCX_D_T3EX 1
`define PCX_D_CP2 3
`define PCX_D_T4EX 4

`define PCX_RST_CFG 8'h00
`define PCX_RST_LATCH 8'hff
`define PCX_RST_MODE 8'h00
`define PCX_RST_MDIN 8'hff

// signal slots, lowest index has highest priority
`define PCX_SIG_TX0 0
`define PCX_SIG_RX0 1
`define PCX_SIG_NSS 5
`define PCX_SIG_SDA 6
`define PCX_SIG_SCL 7
`define PCX_SIG_TX1 8
`define PCX_SIG_RX1 9
`define PCX_SIG_CEX0 10
`define PCX_INPUT_ONLY 33'h1_bff1_0202

`endif

// file: pcx_pkg.sv
// Purpose: shared types of the crossbar and port block
// Assumes: nothing beyond the register header
// Notes: write channel states are one-hot
`default_nettype none
package pcx_pkg;
  typedef enum logic [3:0] {
    PCX_WR_IDLE = 4'h1,
    PCX_WR_HAVE_A = 4'h2,
    PCX_WR_HAVE_D = 4'h4,
    PCX_WR_RESP = 4'h8
  } pcx_wr_e;

  typedef struct packed {
    logic val;
    logic drv;
    logic od;
  } pcx_drive_s;

  typedef logic [7:0] pcx_byte_t;
endpackage
`default_nettype wire

// file: pcx_alloc.sv
// Purpose: priority allocation of enabled peripheral signals to free pins
// Assumes: pure combinational, lowest signal index wins the lowest free pin
// Notes: the k-th enabled signal lands on the k-th free pin
`default_nettype none
module pcx_alloc #(
  parameter int NSIG = 33,
  parameter int NPIN = 32
) (
  input wire logic [NSIG-1:0] sig_en,
  input wire logic [NPIN-1:0] pin_free,
  output logic [NPIN-1:0] pin_alloc,
  output logic [NPIN-1:0][5:0] pin_sig,
  output logic [NSIG-1:0] sig_alloc,
  output logic [NSIG-1:0][4:0] sig_pin
);
  logic [NPIN-1:0][6:0] pin_rank;
  logic [NSIG-1:0][6:0] sig_rank;

  always_comb begin
    logic [6:0] cnt;
    cnt = 7'h00;
    for (int p = 0; p < NPIN; p++) begin
      pin_rank[p] = cnt;
      cnt = cnt + 7'(pin_free[p]);
    end
    cnt = 7'h00;
    for (int s = 0; s < NSIG; s++) begin
      sig_rank[s] = cnt;
      cnt = cnt + 7'(sig_en[s]);
    end
  end

  always_comb begin
    pin_alloc = '0;
    pin_sig = '0;
    sig_alloc = '0;
    sig_pin = '0;
    for (int p = 0; p < NPIN; p++) begin
      for (int s = 0; s < NSIG; s++) begin
        if (pin_free[p] && sig_en[s] && pin_rank[p] == sig_rank[s]) begin // [R18]
          pin_alloc[p] = 1'b1;
          pin_sig[p] = 6'(s);
          sig_alloc[s] = 1'b1;
          sig_pin[s] = 5'(p);
        end
      end
    end
  end
endmodule // pcx_alloc
`default_nettype wire

// file: pcx_pad.sv
// Purpose: output driver of one port pin
// Assumes: enable low holds the driver off
// Notes: registered so the pad sees no decode glitches
`default_nettype none
module pcx_pad (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pcx_pkg::pcx_drive_s drive,
  input wire logic enable,
  output logic pin_o,
  output logic pin_oe
);
  logic nxt_oe;

  // open-drain only pulls low, push-pull drives both levels
  assign nxt_oe = enable && drive.drv && (!drive.od || !drive.val); // [R12] [R13]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe <= 1'b0;
      pin_o <= 1'b0;
    end else begin
      pin_oe <= nxt_oe;
      pin_o <= drive.val && enable;
    end
  end
endmodule // pcx_pad
`default_nettype wire

// file: pcx_board.sv
// Purpose: board pull-ups and peripheral lines around the crossbar
// Assumes: every pin but pin 1 pulled up; only the receive pin has an outside driver
// Notes: transmit and receive levels are set by the bench
`default_nettype none
module pcx_board (
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  input wire logic tx_level,
  input wire logic rx_level,
  output logic [31:0] pin_i,
  output logic [32:0] periph_out,
  output logic [32:0] periph_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pin goes to its pull-up, pin 1 to rx_level; never keeps the last driven value
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : ((i == 1) ? rx_level : 1'b1);
    end
  end
  // receive slot wants to drive too, so input-only and mode 0 forcing are both exercised
  assign periph_out = {31'h0000_0000, tx_level, tx_level};
  assign periph_drv = {31'h0000_0000, 2'h3};
endmodule // pcx_board
`default_nettype wire

// file: priority_crossbar_port_io_tb.sv
// Purpose: register and pin checks of the crossbar block
// Assumes: one serial port enabled at a time; reservation off; serial mode 0 in one check only
// Notes: pad outputs checked three cycles after a write, past the register lag
`default_nettype none
module priority_crossbar_port_io_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [31:0] s_axi_rdata, rd_data, pin_i, pin_o, pin_oe;
  logic [32:0] periph_out, periph_drv, periph_in;
  logic uart0_mode0 = 1'b0, uart1_mode0 = 1'b0, spi_three_wire = 1'b0, emif_multiplexed = 1'b0;
  logic tx_level = 1'b0, rx_level = 1'b0;
  int miscompares = 0, check_count = 0, cyc = 0;
  pcx_crossbar u_pcx_crossbar (.*);
  pcx_board u_pcx_board (.pin_o(pin_o), .pin_oe(pin_oe), .tx_level(tx_level), .rx_level(rx_level),
    .pin_i(pin_i), .periph_out(periph_out), .periph_drv(periph_drv));
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic end_sim();
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far above the sixty-odd cycles the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // entered and left just after a rising edge; readiness sampled mid-cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    chk("bresp", 32'h0000_0000, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
  endtask
  task automatic settle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h08); chk("cfg_c reset", 32'h0000_0000, rd_data);
    rd(8'h20); chk("mode reset", 32'h0000_0000, rd_data);
    rd(8'h30); chk("mdin reset", 32'h0000_00ff, rd_data);
    rd(8'h40); chk("latch reset", 32'h0000_00ff, rd_data);
    rd(8'hfc); chk("unmapped resp", 32'h0000_0002, {30'h0, rd_resp});
    // latch low with drivers still globally off
    wr(8'h10, 8'h00);
    settle(); chk("oe before enable", 32'h0000_0000, pin_oe);
    @(posedge aclk);
    rd(8'h40); chk("latch alias", 32'h0000_0000, rd_data);
    rd(8'h10); chk("pin read", 32'h0000_00fd, rd_data);
    wr(8'h00, 8'h04);
    wr(8'h08, 8'h10);
    settle(); chk("oe tx rx gpio", 32'h0000_00fd, pin_oe);
    chk("tx low", 32'h0000_0000, {31'h0, pin_o[0]});
    chk("rx path low", 32'h0000_0000, {31'h0, periph_in[1]});
    @(posedge aclk);
    rx_level <= 1'b1;
    tx_level <= 1'b1;
    settle(); chk("rx path high", 32'h0000_0001, {31'h0, periph_in[1]});
    chk("od tx high floats", 32'h0000_00fc, pin_oe);
    @(posedge aclk);
    wr(8'h20, 8'hff);
    wr(8'h10, 8'h04);
    settle(); chk("pp oe", 32'h0000_00fd, pin_oe);
    chk("pp level", 32'h0000_0007, {24'h0, pin_o[7:0]});
    @(posedge aclk);
    rd(8'h10); chk("pin read pp", 32'h0000_0007, rd_data);
    uart0_mode0 <= 1'b1;
    settle(); chk("mode0 rx forced od", 32'h0000_0000, {31'h0, pin_oe[1]});
    @(posedge aclk);
    uart0_mode0 <= 1'b0;
    wr(8'h00, 8'h00);
    settle(); chk("gpio oe", 32'h0000_00ff, pin_oe);
    chk("gpio level", 32'h0000_0004, {24'h0, pin_o[7:0]});
    chk("rx detached", 32'h0000_0000, {31'h0, periph_in[1]});
    @(posedge aclk);
    end_sim();
  end
endmodule // priority_crossbar_port_io_tb
`default_nettype wire
